// >>> rtl/aimx_top.sv
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module aimx_top (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output aimx_pkg::aimx_route_t   first_mux_setting_route,
  output aimx_pkg::aimx_route_t   second_mux_setting_route,
  output logic      [15:0]        pin_port_read_enable,
  output logic      [15:0]        pin_analog_sample_enable
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] input_select;       // adc_input_select
  logic [15:0] pin_config;         // adc_pin_analog_config_low
  logic        wr_en;              // write strobe in access phase
  logic        addr_hit;           // address maps to a register

  // ****************************************************************
  // apb slave, zero wait states
  // ****************************************************************
  assign pready   = 1'b1;
  assign addr_hit = (paddr == aimx_pkg::INPUT_SELECT_ADDR) || (paddr == aimx_pkg::PIN_CONFIG_ADDR);
  assign pslverr  = psel && penable && !addr_hit;  // unmapped address
  assign wr_en    = psel && penable && pwrite;

  // input select register; unimplemented bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_select <= aimx_pkg::INPUT_SELECT_RESET;
    end else if (wr_en && paddr == aimx_pkg::INPUT_SELECT_ADDR) begin
      input_select <= pwdata[15:0] & aimx_pkg::INPUT_SELECT_MASK;
    end
  end

  // pin configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_config <= aimx_pkg::PIN_CONFIG_RESET;  // analog after reset
    end else if (wr_en && paddr == aimx_pkg::PIN_CONFIG_ADDR) begin
      pin_config <= pwdata[15:0];
    end
  end

  // read data registered in the setup phase, valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        aimx_pkg::INPUT_SELECT_ADDR: prdata <= {16'h0000, input_select};
        aimx_pkg::PIN_CONFIG_ADDR:   prdata <= {16'h0000, pin_config};
        default:                     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // pin mode outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_port_read_enable     <= 16'h0000;
      pin_analog_sample_enable <= 16'hffff;
    end else begin
      pin_port_read_enable     <= pin_config;
      pin_analog_sample_enable <= ~pin_config;
    end
  end

  // ****************************************************************
  // multiplexer decoders
  // ****************************************************************
  aimx_decode u_dec_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .pos_code (input_select[aimx_pkg::FIRST_MUX_SETTING_POS_LSB +: 5]),
    .neg_sel  (input_select[aimx_pkg::FIRST_MUX_SETTING_NEG_BIT]),
    .route    (first_mux_setting_route)
  );

  aimx_decode u_dec_b (
    .pclk     (pclk),
    .presetn  (presetn),
    .pos_code (input_select[aimx_pkg::SECOND_MUX_SETTING_POS_LSB +: 5]),
    .neg_sel  (input_select[aimx_pkg::SECOND_MUX_SETTING_NEG_BIT]),
    .route    (second_mux_setting_route)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  // route checks start one edge after reset release: the decoders load at that edge
  a_band_gap_b: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[12:8] == 5'h11 |=> second_mux_setting_route.band_gap && second_mux_setting_route.ext_onehot == 16'h0000)
    else $error("setting B band gap not routed");

  a_band_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[4:0] == 5'h11 |=> first_mux_setting_route.band_gap && !first_mux_setting_route.half_gap)
    else $error("setting A band gap not routed");

  a_half_gap: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[4:0] == 5'h10 |=> first_mux_setting_route.half_gap && !first_mux_setting_route.band_gap)
    else $error("half band gap not routed");

  a_half_gap_b: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[12:8] == 5'h10 |=> second_mux_setting_route.half_gap && second_mux_setting_route.ext_onehot == 16'h0000)
    else $error("setting B half band gap not routed");

  a_input_fifteen: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[12:8] == 5'h0f |=> second_mux_setting_route.ext_onehot == 16'h8000)
    else $error("input 15 not routed");

  a_fifteen_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[4:0] == 5'h0f |=> first_mux_setting_route.ext_onehot == 16'h8000)
    else $error("setting A input 15 not routed");

  a_input_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[4] == 1'b0 |=> first_mux_setting_route.ext_onehot == (16'h0001 << $past(input_select[3:0])))
    else $error("external input index mismatch");

  a_onehot_b: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[12] == 1'b0 |=> second_mux_setting_route.ext_onehot == (16'h0001 << $past(input_select[11:8])))
    else $error("setting B external index mismatch");

  a_input_four: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[4:0] == 5'h04 |=> first_mux_setting_route.ext_onehot == 16'h0010)
    else $error("input 4 not routed");

  a_input_three: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[4:0] == 5'h03 |=> first_mux_setting_route.ext_onehot == 16'h0008)
    else $error("input 3 not routed");

  a_three_b: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[12:8] == 5'h03 |=> second_mux_setting_route.ext_onehot == 16'h0008)
    else $error("setting B input 3 not routed");

  a_source_a: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0({first_mux_setting_route.ext_onehot, first_mux_setting_route.half_gap, first_mux_setting_route.band_gap}))
    else $error("setting A drives two sources");

  a_source_b: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0({second_mux_setting_route.ext_onehot, second_mux_setting_route.half_gap, second_mux_setting_route.band_gap}))
    else $error("setting B drives two sources");

  // ****************************************************************
  // pin mode, negative select and unused code checks
  // ****************************************************************
  a_pin_digital: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == aimx_pkg::PIN_CONFIG_ADDR |=> ##1 pin_port_read_enable == $past(pwdata[15:0], 2))
    else $error("digital pin mode not applied");

  a_port_follow: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> pin_port_read_enable == $past(pin_config))
    else $error("port read enable does not follow config");

  a_analog_follow: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> pin_analog_sample_enable == ~$past(pin_config))
    else $error("analog sample enable does not follow config");

  a_pin_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == aimx_pkg::PIN_CONFIG_ADDR |=> pin_config == $past(pwdata[15:0]))
    else $error("pin config write lost");

  a_pin_analog: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_analog_sample_enable & pin_port_read_enable) == 16'h0000)
    else $error("pin both analog and digital");

  a_negative_sel: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[7] |=> first_mux_setting_route.neg_an1 && !first_mux_setting_route.neg_ref)
    else $error("setting A negative select wrong");

  a_neg_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && !input_select[7] |=> first_mux_setting_route.neg_ref && !first_mux_setting_route.neg_an1)
    else $error("setting A negative reference not routed");

  a_neg_b: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> second_mux_setting_route.neg_an1 == $past(input_select[15]) && second_mux_setting_route.neg_ref != second_mux_setting_route.neg_an1)
    else $error("setting B negative select wrong");

  a_unused_code: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[4:0] > 5'h11 |=> first_mux_setting_route.ext_onehot == 16'h0000 && !first_mux_setting_route.band_gap
      && !first_mux_setting_route.half_gap)
    else $error("unused code selects a source");

  a_unused_b: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && input_select[12:8] > 5'h11 |=> second_mux_setting_route.ext_onehot == 16'h0000 && !second_mux_setting_route.band_gap
      && !second_mux_setting_route.half_gap)
    else $error("setting B unused code selects a source");

  // ****************************************************************
  // bus checks
  // ****************************************************************
  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == aimx_pkg::INPUT_SELECT_ADDR |=> input_select == ($past(pwdata[15:0]) & aimx_pkg::INPUT_SELECT_MASK))
    else $error("input select write wrong");

  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (input_select & ~aimx_pkg::INPUT_SELECT_MASK) == 16'h0000)
    else $error("unimplemented select bits set");

  a_read_select: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == aimx_pkg::INPUT_SELECT_ADDR |=> prdata == {16'h0000, $past(input_select)})
    else $error("input select read data wrong");

  a_read_pin: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == aimx_pkg::PIN_CONFIG_ADDR |=> prdata == {16'h0000, $past(pin_config)})
    else $error("pin config read data wrong");

  a_unmapped_kept: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && !addr_hit |=> pin_config == $past(pin_config) && input_select == $past(input_select))
    else $error("unmapped write changed a register");

endmodule

// >>> rtl/aimx_pkg.sv
package aimx_pkg;

  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [11:0] INPUT_SELECT_ADDR = 12'h000;  // adc_input_select
  localparam logic [11:0] PIN_CONFIG_ADDR   = 12'h004;  // adc_pin_analog_config_low

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FIRST_MUX_SETTING_POS_LSB = 0;   // first_mux_setting_positive_select 4:0
  localparam int FIRST_MUX_SETTING_NEG_BIT = 7;   // first_mux_setting_negative_select
  localparam int SECOND_MUX_SETTING_POS_LSB = 8;   // second_mux_setting_positive_select 12:8
  localparam int SECOND_MUX_SETTING_NEG_BIT = 15;  // second_mux_setting negative select

  // writable bits of the input select register
  localparam logic [15:0] INPUT_SELECT_MASK = 16'h9f9f;

  // reset values
  localparam logic [15:0] INPUT_SELECT_RESET = 16'h0000;
  localparam logic [15:0] PIN_CONFIG_RESET   = 16'h0000;

  // ****************************************************************
  // positive select codes
  // ****************************************************************
  localparam logic [4:0] CODE_LAST_EXTERNAL = 5'h0f;  // analog_input_15
  localparam logic [4:0] CODE_HALF_BAND_GAP = 5'h10;  // half_band_gap_reference
  localparam logic [4:0] CODE_BAND_GAP      = 5'h11;  // band_gap_reference

  // decoded positive and negative source of one mux setting
  typedef struct packed {
    logic [15:0] ext_onehot;  // one-hot external input select
    logic        half_gap;    // half band gap selected
    logic        band_gap;    // full band gap selected
    logic        neg_an1;     // negative input is analog input 1
    logic        neg_ref;     // negative input is negative reference
  } aimx_route_t;

endpackage

// >>> rtl/aimx_decode.sv
`timescale 1ns/1ps
// registered decoder of one multiplexer setting
module aimx_decode (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [4:0]         pos_code,
  input  wire logic               neg_sel,
  output aimx_pkg::aimx_route_t   route
);

  // ****************************************************************
  // code to route decode
  // ****************************************************************
  function automatic aimx_pkg::aimx_route_t decode(input logic [4:0] code, input logic neg);
    aimx_pkg::aimx_route_t r;
    r = '0;
    if (code <= aimx_pkg::CODE_LAST_EXTERNAL) begin
      r.ext_onehot = 16'h0001 << code[3:0];  // index equals code
    end
    r.half_gap = (code == aimx_pkg::CODE_HALF_BAND_GAP);
    r.band_gap = (code == aimx_pkg::CODE_BAND_GAP);
    r.neg_an1  = neg;
    r.neg_ref  = !neg;
    return r;
  endfunction

  // route held in flip-flops; unused codes select nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route <= '0;
    end else begin
      route <= decode(pos_code, neg_sel);
    end
  end

endmodule

// >>> dv/aimx_top_test.sv
`timescale 1ns/1ps
module aimx_top_test;
  // ****************************************************************
  // bench signals
  // ****************************************************************
  logic                  pclk, presetn, psel, penable, pwrite;  // clock, reset, bus controls
  logic [11:0]           paddr;                                 // bus address
  logic [31:0]           pwdata, prdata, rd;                    // write data, read data, last read
  logic                  pready, pslverr, err;                  // handshake and last error flag
  aimx_pkg::aimx_route_t first_mux_setting_route, second_mux_setting_route;              // decoded routes
  logic [15:0]           pin_port_read_enable, pin_analog_sample_enable, pat;  // pin outputs
  logic [4:0]            code_a, code_b;                        // codes under test
  int                    failures, n_compared;                  // counters

  aimx_top i_aimx_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_mux_setting_route(first_mux_setting_route), .second_mux_setting_route(second_mux_setting_route), .pin_port_read_enable(pin_port_read_enable),
    .pin_analog_sample_enable(pin_analog_sample_enable));

  // free running clock, 10 ns period
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  // compare one value and count it
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer: setup, then access until pready, data taken at that edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= addr; pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // expected route for a positive code and negative select
  function automatic aimx_pkg::aimx_route_t route_of(input logic [4:0] c, input logic n);
    route_of = '0;
    if (c < 5'h10) route_of.ext_onehot = 16'h0001 << c;
    route_of.half_gap = (c == 5'h10);
    route_of.band_gap = (c == 5'h11);
    route_of.neg_an1  = n;
    route_of.neg_ref  = ~n;
  endfunction

  // verdict and end of run
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #50000;
    failures++;
    $display("watchdog expired");
    give_verdict();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    failures = 0; n_compared = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check("port read after reset", 32'h0, {16'h0, pin_port_read_enable});
    check("analog sample after reset", 32'hffff, {16'h0, pin_analog_sample_enable});
    apb(1'b0, 12'h004, 32'h0);
    check("pin config reset", 32'h0, rd);
    check("ready level", 32'h1, {31'h0, pready});
    apb(1'b0, 12'h000, 32'h0);
    check("input select reset", 32'h0, rd);
    $display("test reset done");
    // codes 0 to 19 on both settings, unused 0x12 and 0x13 included, negatives alternating
    for (int c = 0; c < 20; c++) begin
      code_b = c[4:0];
      code_a = 5'(19 - c);
      apb(1'b1, 12'h000, {16'h0, c[0], 2'b00, code_b, ~c[0], 2'b00, code_a});
      @(posedge pclk);
      #1;
      check("second_mux_setting route", {12'h0, route_of(code_b, c[0])}, {12'h0, second_mux_setting_route});
      check("first_mux_setting route", {12'h0, route_of(code_a, ~c[0])}, {12'h0, first_mux_setting_route});
    end
    apb(1'b1, 12'h000, 32'hffffffff);
    apb(1'b0, 12'h000, 32'h0);
    check("input select readback", 32'h9f9f, rd);
    $display("test input select done");
    // pin configuration patterns, upper bus half must be ignored
    for (int i = 0; i < 3; i++) begin
      pat = (i == 0) ? 16'ha5c3 : (i == 1) ? 16'hffff : 16'h0001;
      apb(1'b1, 12'h004, {16'h5a5a, pat});
      apb(1'b0, 12'h004, 32'h0);
      check("pin config readback", {16'h0, pat}, rd);
      check("pin error flag", 32'h0, {31'h0, err});
      check("port read enable", {16'h0, pat}, {16'h0, pin_port_read_enable});
      check("analog sample enable", {16'h0, ~pat}, {16'h0, pin_analog_sample_enable});
    end
    $display("test pin config done");
    // unmapped address: refused, state untouched
    apb(1'b1, 12'h008, 32'h0000ffff);
    check("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped read data", 32'h0, rd);
    check("port read kept", 32'h0001, {16'h0, pin_port_read_enable});
    $display("test unmapped done");
    give_verdict();
  end
endmodule
